//--- common/anr_pkg.sv
// Purpose: shared constants for the auto-negotiation ability register bank
// Assumes: 16-bit registers, one per aligned 32-bit APB word
// Notes: register indices are kept as printed; byte address is four times the index
package anr_pkg;

  // register indices and the byte addresses derived from them
  localparam logic [3:0] IDX_ADVERT = 4'h4;
  localparam logic [3:0] IDX_PARTNER = 4'h5;
  localparam logic [3:0] IDX_EXPANSION = 4'h6;
  localparam logic [3:0] IDX_NEXT_PAGE_RX = 4'h8;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_ADVERT = {2'h0, IDX_ADVERT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PARTNER = {2'h0, IDX_PARTNER, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EXPANSION = {2'h0, IDX_EXPANSION, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_NEXT_PAGE_RX = {2'h0, IDX_NEXT_PAGE_RX, 2'h0};

  localparam int unsigned REG_W = 16;

  // advertisement layout
  localparam logic [15:0] ADV_RW_MASK = 16'hade0;
  localparam logic [15:0] ADV_SELECTOR = 16'h0001;
  localparam logic [15:0] ADV_RESET = 16'h0001;
  localparam int unsigned ADV_STRAP_LSB = 5;
  localparam int unsigned ADV_STRAP_W = 4;

  // partner ability layout
  localparam logic [15:0] PARTNER_MASK = 16'hefff;
  localparam logic [15:0] PARTNER_RESET = 16'h0000;
  localparam int unsigned PARTNER_NP_BIT = 15;

  // expansion layout
  localparam int unsigned EXP_LOC_VALID_BIT = 6;
  localparam int unsigned EXP_LOC_SELECT_BIT = 5;
  localparam int unsigned EXP_PD_FAULT_BIT = 4;
  localparam int unsigned EXP_PARTNER_NP_BIT = 3;
  localparam int unsigned EXP_LOCAL_NP_BIT = 2;
  localparam int unsigned EXP_PAGE_RX_BIT = 1;
  localparam int unsigned EXP_PARTNER_AN_BIT = 0;
  localparam logic EXP_LOC_SELECT_RESET = 1'b1;

  // strap capture phase
  typedef enum logic [0:0] {
    PH_STRAP,
    PH_RUN
  } anr_phase_t;

endpackage : anr_pkg

//--- hw/anr_regs.sv
// Purpose: auto-negotiation ability register bank behind an APB slave
// Assumes: negotiation logic runs on clk_sys; straps are asynchronous pins
// Notes: zero wait-state slave, read data prepared in the setup cycle
//        page-received flag clears only if the read showed it set; a new page wins
//        location select is fixed at register 8, so next pages never touch the partner register
//
// What this block does
// - advertisement bit 5, ten half duplex, read-write, power-up value from strap
// - advertisement bits 4:0 hold selector 00001 for the Ethernet protocol
// - partner ability register is read-only, captured from received base page
// - with next pages, partner register keeps the base page; next pages go to register 8
// - partner bit 15 shows partner next-page request, resets to 0
// - partner bit 14 shows partner acknowledge, updated from received base pages
// - partner bit 13 shows remote fault signalled by the partner
// - partner bits 11 and 10 show asymmetric and symmetric pause, read-only
// - partner bits 9..5 show T4, 100 full, 100 half, 10 full, 10 half
// - partner bits 4:0 hold partner selector, reset zero, read-only
// - partner bit 12 and expansion bits 15:7 read zero, ignore writes
// - expansion bit 6 reads constant 1: storage location is reported
// - expansion bit 5 picks next-page store: 1 register 8, 0 register 5
// - expansion bit 4 set while parallel detection reports a fault
// - expansion bit 3 shows partner next-page capability, resets 0
// - expansion bit 2 reads fixed 1: local device can send next pages
// - expansion bit 1 set on page reception, cleared by reading the register
// - expansion bit 0 shows whether partner supports auto-negotiation
// - advertisement bits 8..6 read-write with strap defaults
// - register 8 holds the most recent next page from the partner
`timescale 1ns/10ps
`default_nettype none

module anr_regs
  import anr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // strap pins for advertisement bits 8..5
  input wire logic [ADV_STRAP_W-1:0] strapAdvert,
  // from the negotiation state machine
  input wire logic pageValid,
  input wire logic pageIsBase,
  input wire logic [REG_W-1:0] pageWord,
  input wire logic parallelDetectFault,
  input wire logic partnerAutonegCapable,
  // to the negotiation state machine
  output logic [REG_W-1:0] advertWord
);

  typedef struct packed {
    logic [ADV_STRAP_W-1:0] strapMeta;
    logic [ADV_STRAP_W-1:0] strapSync;
    anr_phase_t phase;
    logic [REG_W-1:0] advert;
    logic [REG_W-1:0] partner;
    logic [REG_W-1:0] nextPageRx;
    logic locSelect;
    logic pdFault;
    logic partnerNp;
    logic pageRx;
    logic partnerAn;
    logic [31:0] rdata;
    logic slvErr;
  } anr_state_t;

  anr_state_t st_reg;
  anr_state_t st_next;

  logic setupRd;
  logic setupCyc;
  logic accessCyc;
  logic wrAdvert;
  logic clrPageRx;
  logic mapped;
  logic [REG_W-1:0] expView;
  logic [REG_W-1:0] wrMerged;

  // bus phases
  assign setupCyc = psel && !penable;
  assign accessCyc = psel && penable;
  assign setupRd = setupCyc && !pwrite;
  // unmapped addresses are refused; mapped read-only registers take writes silently
  assign mapped = (paddr == ADDR_ADVERT) || (paddr == ADDR_PARTNER) ||
                  (paddr == ADDR_EXPANSION) || (paddr == ADDR_NEXT_PAGE_RX);
  assign wrAdvert = accessCyc && pwrite && (paddr == ADDR_ADVERT);
  // only clear what the reader actually saw, so an event after the snapshot survives
  assign clrPageRx = accessCyc && !pwrite && (paddr == ADDR_EXPANSION) &&
                     st_reg.rdata[EXP_PAGE_RX_BIT];

  // expansion view: upper bits zero, two fixed ones
  always_comb begin
    expView = '0;
    expView[EXP_LOC_VALID_BIT] = 1'b1;
    expView[EXP_LOC_SELECT_BIT] = st_reg.locSelect;
    expView[EXP_PD_FAULT_BIT] = st_reg.pdFault;
    expView[EXP_PARTNER_NP_BIT] = st_reg.partnerNp;
    expView[EXP_LOCAL_NP_BIT] = 1'b1;
    expView[EXP_PAGE_RX_BIT] = st_reg.pageRx;
    expView[EXP_PARTNER_AN_BIT] = st_reg.partnerAn;
  end

  // byte lanes of a write; only writable advert bits land, selector stays fixed
  always_comb begin
    // lanes 2 and 3 carry nothing: each register sits in the low half of its word
    wrMerged = st_reg.advert;
    if (pstrb[0]) begin
      wrMerged[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      wrMerged[15:8] = pwdata[15:8];
    end
    wrMerged = (wrMerged & ADV_RW_MASK) | ADV_SELECTOR;
  end

  // next state of the whole bank
  always_comb begin
    st_next = st_reg;
    // two-flop synchroniser for the strap pins
    st_next.strapMeta = strapAdvert;
    st_next.strapSync = st_reg.strapMeta;
    case (st_reg.phase)
      PH_STRAP: begin
        // the strap is taken once, after the synchroniser has settled past reset
        st_next.advert[ADV_STRAP_LSB +: ADV_STRAP_W] = st_reg.strapSync;
        st_next.phase = PH_RUN;
      end
      PH_RUN: begin
        if (wrAdvert) begin
          st_next.advert = wrMerged;
        end
      end
      default: begin
        st_next.phase = PH_RUN;
      end
    endcase
    // received pages: base pages to the partner register, next pages as located
    // location select has no write path, so today only base pages reach the partner register
    if (pageValid) begin
      if (pageIsBase || !st_reg.locSelect) begin
        st_next.partner = pageWord & PARTNER_MASK;
      end else begin
        st_next.nextPageRx = pageWord;
      end
      if (pageIsBase) begin
        st_next.partnerNp = pageWord[PARTNER_NP_BIT];
      end
    end
    st_next.pdFault = parallelDetectFault;
    st_next.partnerAn = partnerAutonegCapable;
    // set wins over the read clear
    st_next.pageRx = (st_reg.pageRx && !clrPageRx) || pageValid;
    // read data and error are prepared in the setup cycle
    if (setupCyc) begin
      st_next.slvErr = !mapped;
      st_next.rdata = '0;
      if (setupRd) begin
        case (paddr)
          ADDR_ADVERT: st_next.rdata = {16'h0000, st_reg.advert};
          ADDR_PARTNER: st_next.rdata = {16'h0000, st_reg.partner};
          ADDR_EXPANSION: st_next.rdata = {16'h0000, expView};
          ADDR_NEXT_PAGE_RX: st_next.rdata = {16'h0000, st_reg.nextPageRx};
          default: st_next.rdata = '0;
        endcase
      end
    end
    // straps are not reset: the synchroniser keeps running so the strap phase sees settled pins
    if (!rst_n) begin
      st_next.phase = PH_STRAP;
      st_next.advert = ADV_RESET;
      st_next.partner = PARTNER_RESET;
      st_next.nextPageRx = '0;
      st_next.locSelect = EXP_LOC_SELECT_RESET;
      st_next.pdFault = 1'b0;
      st_next.partnerNp = 1'b0;
      st_next.pageRx = 1'b0;
      st_next.partnerAn = 1'b0;
      st_next.rdata = '0;
      st_next.slvErr = 1'b0;
    end
  end

  // single state register, synchronous reset folded into the next state
  always_ff @(posedge clk_sys) begin
    st_reg <= st_next;
  end

  // outputs
  assign prdata = st_reg.rdata;
  // zero wait states: every access completes on its first access edge
  assign pready = 1'b1;
  assign pslverr = st_reg.slvErr && accessCyc;
  assign advertWord = st_reg.advert;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  selector_fixed_a: assert property (
    st_reg.advert[4:0] == ADV_SELECTOR[4:0])
    else $error("advert selector not 00001");

  strap_load_a: assert property (
    st_reg.phase == PH_STRAP |=>
      st_reg.advert[ADV_STRAP_LSB +: ADV_STRAP_W] == $past(st_reg.strapSync))
    else $error("strap not loaded into advert");

  advert_write_a: assert property (
    wrAdvert && st_reg.phase == PH_RUN && (&pstrb) |=>
      st_reg.advert == ((($past(pwdata[15:0])) & ADV_RW_MASK) | ADV_SELECTOR))
    else $error("advert write lost");

  partner_reserved_a: assert property (
    !st_reg.partner[12] && (expView[15:7] == 9'h000))
    else $error("reserved bit set");

  exp_fixed_a: assert property (
    setupRd && paddr == ADDR_EXPANSION |=>
      prdata[EXP_LOC_VALID_BIT] && prdata[EXP_LOCAL_NP_BIT] && prdata[31:16] == 16'h0000)
    else $error("expansion fixed bits wrong");

  base_capture_a: assert property (
    pageValid && pageIsBase |=> st_reg.partner == ($past(pageWord) & PARTNER_MASK)
      && st_reg.partnerNp == $past(pageWord[PARTNER_NP_BIT]))
    else $error("base page not captured");

  next_page_store_a: assert property (
    pageValid && !pageIsBase && st_reg.locSelect |=>
      st_reg.nextPageRx == $past(pageWord) && $stable(st_reg.partner))
    else $error("next page stored wrongly");

  page_rx_set_a: assert property (
    pageValid |=> st_reg.pageRx)
    else $error("page received flag not set");

  page_rx_clear_a: assert property (
    clrPageRx && !pageValid |=> !st_reg.pageRx ##1 (st_reg.pageRx == $past(pageValid)))
    else $error("page received flag not cleared by read");

  unmapped_err_a: assert property (
    setupCyc && !mapped ##1 accessCyc |-> pslverr && pready)
    else $error("unmapped access not refused");

  // advertisement: fixed zeros, untouched without a write, byte lanes honoured
  advert_ro_zero_a: assert property (
    (st_reg.advert & ~(ADV_RW_MASK | ADV_SELECTOR)) == 16'h0000)
    else $error("read-only advert bit set");

  advert_hold_a: assert property (
    !wrAdvert && st_reg.phase == PH_RUN |=> $stable(st_reg.advert))
    else $error("advert changed without a write");

  phase_run_a: assert property (
    st_reg.phase == PH_STRAP |=> st_reg.phase == PH_RUN)
    else $error("strap phase did not end");

  lane_low_write_a: assert property (
    wrAdvert && st_reg.phase == PH_RUN && pstrb[0] |=>
      st_reg.advert[7:5] == $past(pwdata[7:5]))
    else $error("lower advert byte write lost");

  lane_low_only_a: assert property (
    wrAdvert && st_reg.phase == PH_RUN && pstrb[1:0] == 2'b01 |=>
      st_reg.advert[15:8] == $past(st_reg.advert[15:8]))
    else $error("upper advert byte written without its strobe");

  lane_high_only_a: assert property (
    wrAdvert && st_reg.phase == PH_RUN && pstrb[1:0] == 2'b10 |=>
      st_reg.advert[7:0] == $past(st_reg.advert[7:0]))
    else $error("lower advert byte written without its strobe");

  // reset values are checked while reset is low, so these opt out of the default disable
  reset_values_a: assert property (
    disable iff (1'b0)
    !rst_n |=> st_reg.partner == PARTNER_RESET && !st_reg.partnerNp && !st_reg.pageRx &&
      !st_reg.pdFault && !st_reg.partnerAn && st_reg.advert == ADV_RESET)
    else $error("register bank not at reset values");

  reset_location_a: assert property (
    disable iff (1'b0)
    !rst_n |=> st_reg.locSelect == EXP_LOC_SELECT_RESET && st_reg.phase == PH_STRAP)
    else $error("location select or strap phase not reset");

  // received pages are the only thing that moves the partner side
  partner_hold_a: assert property (
    !pageValid |=> $stable(st_reg.partner))
    else $error("partner register changed without a page");

  partner_np_hold_a: assert property (
    !(pageValid && pageIsBase) |=> $stable(st_reg.partnerNp))
    else $error("partner next-page flag changed without a base page");

  next_page_hold_a: assert property (
    !pageValid |=> $stable(st_reg.nextPageRx))
    else $error("stored next page changed without a page");

  partner_read_a: assert property (
    setupRd && paddr == ADDR_PARTNER |=> prdata == {16'h0000, $past(st_reg.partner)})
    else $error("partner read does not show the register");

  // status levels follow their inputs one cycle later
  pd_mirror_a: assert property (
    1'b1 |=> st_reg.pdFault == $past(parallelDetectFault))
    else $error("parallel detection fault not mirrored");

  an_mirror_a: assert property (
    1'b1 |=> st_reg.partnerAn == $past(partnerAutonegCapable))
    else $error("partner autoneg ability not mirrored");

  loc_select_read_a: assert property (
    setupRd && paddr == ADDR_EXPANSION |=> prdata[EXP_LOC_SELECT_BIT])
    else $error("next-page location not register 8");

  // page-received flag: sticky until a read that saw it, and never set by itself
  page_rx_hold_a: assert property (
    st_reg.pageRx && !clrPageRx |=> st_reg.pageRx)
    else $error("page received flag lost without a read");

  page_rx_quiet_a: assert property (
    !st_reg.pageRx && !pageValid |=> !st_reg.pageRx)
    else $error("page received flag set without a page");

  // bus side: mapped addresses never error, upper half always zero
  mapped_no_err_a: assert property (
    setupCyc && mapped ##1 accessCyc |-> !pslverr)
    else $error("mapped access refused");

  upper_half_zero_a: assert property (
    prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");

endmodule : anr_regs

`default_nettype wire

//--- test/anr_neg_model.sv
// Purpose: stand-in for the negotiation logic that feeds received pages
// Assumes: a page arrives as a one-cycle pulse on clk_sys
// Notes: the word is inverted once no page is offered, so stale data never looks valid
`timescale 1ns/10ps
`default_nettype none
module anr_neg_model
  import anr_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // page delivery
  output logic pageValid,
  output logic pageIsBase,
  output logic [REG_W-1:0] pageWord,
  // link status levels
  output logic parallelDetectFault,
  output logic partnerAutonegCapable
);
  // quiet link at start
  initial begin
    pageValid = 1'b0;
    pageIsBase = 1'b0;
    pageWord = 16'h0000;
    parallelDetectFault = 1'b0;
    partnerAutonegCapable = 1'b0;
  end
  // one received page; the acknowledge bit travels inside the word
  task automatic send(input logic base, input logic [REG_W-1:0] w);
    pageValid <= 1'b1;
    pageIsBase <= base;
    pageWord <= w;
    @(posedge clk_sys);
    pageValid <= 1'b0;
    pageIsBase <= ~base;
    pageWord <= ~w; // not held after the pulse
    @(posedge clk_sys);
  endtask : send
  // levels as parallel detection and partner signalling report them
  task automatic status(input logic pd, input logic an);
    parallelDetectFault <= pd;
    partnerAutonegCapable <= an;
    @(posedge clk_sys);
  endtask : status
endmodule : anr_neg_model
`default_nettype wire

//--- test/tb.sv
// Purpose: self-checking bench for the ability register bank
// Assumes: apb slave answers by pready; straps settle during reset
// Notes: the driver queues expected reads, the monitor compares them
`timescale 1ns/10ps
`default_nettype none
module tb
  import anr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, strapAdvert;
  logic pageValid, pageIsBase, parallelDetectFault, partnerAutonegCapable;
  logic [15:0] pageWord, advertWord;
  logic [32:0] expq[$];
  int error_cnt = 0;
  int checks_done = 0;

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  anr_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .strapAdvert(strapAdvert), .pageValid(pageValid),
    .pageIsBase(pageIsBase), .pageWord(pageWord), .parallelDetectFault(parallelDetectFault),
    .partnerAutonegCapable(partnerAutonegCapable), .advertWord(advertWord));
  anr_neg_model u_neg (.clk_sys(clk_sys), .pageValid(pageValid), .pageIsBase(pageIsBase),
    .pageWord(pageWord), .parallelDetectFault(parallelDetectFault),
    .partnerAutonegCapable(partnerAutonegCapable));

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // one transfer, held until pready; idle edge after it so no signal is set twice
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] d,
      input logic err = 1'b0);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    if (!wr) expq.push_back({err, 16'h0000, d});
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  // reads are judged at the edge that completes them
  always @(posedge clk_sys) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0
        && expq.size() > 0) begin
      check({pslverr, prdata}, expq.pop_front());
    end
  end

  // watchdog, far beyond the roughly 140 cycles the tests take
  initial begin
    #50000;
    error_cnt++;
    end_sim();
  end

  initial begin
    logic [15:0] w;
    logic [15:0] x;
    logic [15:0] a;
    void'($urandom(40030));
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    strapAdvert = 4'($urandom);
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // reset contents, straps in advert bits 8..5
    check({17'h0, advertWord}, {17'h0, 7'h00, strapAdvert, 5'h01});
    apb(1'b0, ADDR_ADVERT, {7'h00, strapAdvert, 5'h01});
    apb(1'b0, ADDR_PARTNER, 16'h0000);
    apb(1'b0, ADDR_EXPANSION, 16'h0064);
    // only writable advert bits take a write; read-only registers keep theirs
    apb(1'b1, ADDR_ADVERT, 16'hffff);
    check({17'h0, advertWord}, {17'h0, 16'hade1});
    w = 16'($urandom);
    apb(1'b1, ADDR_ADVERT, w);
    a = (w & 16'hade0) | 16'h0001;
    apb(1'b0, ADDR_ADVERT, a);
    // one byte lane at a time: the other lane keeps what it held
    pstrb <= 4'h1;
    apb(1'b1, ADDR_ADVERT, 16'h0000);
    check({17'h0, advertWord}, {17'h0, a[15:8], 8'h01});
    pstrb <= 4'h2;
    apb(1'b1, ADDR_ADVERT, 16'hffff);
    pstrb <= 4'hf;
    apb(1'b0, ADDR_ADVERT, 16'had01);
    apb(1'b1, ADDR_PARTNER, 16'hffff);
    apb(1'b1, ADDR_EXPANSION, 16'hffff);
    apb(1'b0, ADDR_PARTNER, 16'h0000);
    apb(1'b0, ADDR_EXPANSION, 16'h0064);
    apb(1'b0, 8'h3c, 16'h0000, 1'b1);
    // negotiation restarts only after the advert changes, so pages follow now
    // base pages: captured but bit 12, page flag cleared by the first read
    for (int i = 0; i < 4; i++) begin
      w = {i[0], 15'($urandom)};
      u_neg.send(1'b1, w);
      apb(1'b0, ADDR_PARTNER, w & 16'hefff);
      apb(1'b0, ADDR_EXPANSION, {12'h006, w[15], 3'h6});
      apb(1'b0, ADDR_EXPANSION, {12'h006, w[15], 3'h4});
    end
    // next page goes to register 8, base page stays in place
    x = 16'($urandom);
    u_neg.send(1'b0, x);
    apb(1'b0, ADDR_NEXT_PAGE_RX, x);
    apb(1'b0, ADDR_PARTNER, w & 16'hefff);
    // a page arriving on the clearing read's access edge keeps the flag set
    fork
      apb(1'b0, ADDR_EXPANSION, {12'h006, w[15], 3'h6});
      begin
        @(posedge clk_sys);
        u_neg.send(1'b0, ~x);
      end
    join
    apb(1'b0, ADDR_NEXT_PAGE_RX, ~x);
    apb(1'b0, ADDR_EXPANSION, {12'h006, w[15], 3'h6});
    // status levels are mirrored, not sticky
    u_neg.status(1'b1, 1'b1);
    apb(1'b0, ADDR_EXPANSION, {12'h007, w[15], 3'h5});
    u_neg.status(1'b0, 1'b0);
    apb(1'b0, ADDR_EXPANSION, {12'h006, w[15], 3'h4});
    // second reset in mid-run with other straps: captured pages are gone
    strapAdvert <= ~strapAdvert;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({17'h0, advertWord}, {17'h0, 7'h00, strapAdvert, 5'h01});
    apb(1'b0, ADDR_PARTNER, 16'h0000);
    apb(1'b0, ADDR_NEXT_PAGE_RX, 16'h0000);
    apb(1'b0, ADDR_EXPANSION, 16'h0064);
    end_sim();
  end
endmodule : tb
`default_nettype wire
